// ---- rtl/ptm_consts.vh ----
`ifndef PTM_CONSTS_VH
`define PTM_CONSTS_VH

// path count and per-path register width
`define PTM_NPATH        12
`define PTM_REG_W        16
`define PTM_CFG_W        7
`define PTM_PADDR_W      10

// register indices; byte address is four times the index
`define PTM_IDX_ADDR     8'hC0
`define PTM_IDX_DATA     8'hC1
`define PTM_IDX_USTATE   8'hC2
`define PTM_IDX_UMASK    8'hC3
`define PTM_IDX_UEVENT   8'hC4
`define PTM_IDX_MSTATE   8'hC5
`define PTM_IDX_MMASK    8'hC6
`define PTM_IDX_MEVENT   8'hC7

// indirect address register fields
`define PTM_IA_BUSY      15
`define PTM_IA_RNW       14
`define PTM_IA_LOC_HI    13
`define PTM_IA_LOC_LO    6
`define PTM_IA_PATH_HI   3
`define PTM_IA_PATH_LO   0

// indirect location of the trace configuration word
`define PTM_LOC_CFG      8'h00

// trace configuration word fields
`define PTM_CFG_CRLF     6
`define PTM_CFG_ZERO     5
`define PTM_CFG_FIVE_FRAME_PERSISTENCE     4
`define PTM_CFG_SYNC_DISABLE   3
`define PTM_CFG_SHORT    2
`define PTM_CFG_ALGO_HI  1
`define PTM_CFG_ALGO_LO  0
`define PTM_CFG_RESET    7'h00

// algorithm codes
`define PTM_ALGO_OFF     2'h0
`define PTM_ALGO_1       2'h1
`define PTM_ALGO_2       2'h2
`define PTM_ALGO_3       2'h3

// detection figures
`define PTM_A1_HIST      20
`define PTM_A1_CLR_MIN   5'h10
`define PTM_A2_MSGS      4'h8
`define PTM_A2_PER_LONG  3'h5
`define PTM_A2_PER_SHORT 3'h3
`define PTM_A3_WIN_LAST  4'hF
`define PTM_A3_WINS      2'h3
`define PTM_A3_SAME      6'h30

// indirect access time in clocks, at most 22
`define PTM_BUSY_MAX     22
`define PTM_BUSY_CYC     5'h04

`endif

// ---- rtl/ptm_regs.v ----
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ptm_consts.vh"

// Notes on behaviour
// - indirect read copies selected path's configuration word, zero-extended to 16 bits, into the data register
// - indirect write takes data register contents, started by address register write
// - algorithm 1 holds all unstable bits at zero
// - algorithm 2 sets unstable after 8 messages with differences, no persistence
// - algorithm 2 clears unstable when a persistent message appears
// - algorithm 3 sets unstable on errors in three consecutive 16-byte windows
// - algorithm 3 clears unstable after same byte for 48 frames
// - pending event with enable set asserts the interrupt, cleared enable blocks it
// - unstable event bit sets on each status change, read clears the bits it returned
// - mismatch event bit sets on each status change, read clears the bits it returned
// - algorithm 1 sets mismatch when none of last 20 messages match
// - algorithm 1 clears mismatch when 16 of last 20 messages match
// - algorithm 2 mismatch follows accepted versus expected comparison
// - algorithm 3 holds all mismatch bits at zero
// - configuration word at indirect location 00, seven bits in six fields, default zero
// - algorithm field 00 off, 01 first, 10 second algorithm
// - algorithm off forces status and defect outputs low; 11 selects third
// - address write raises busy, busy falls within 22 clocks
// - short-length bit picks 16-byte else 64-byte messages for algorithms 1, 2; the code only stores this bit, no logic reads it
// - persistence bit picks 5 multiframes, else 3
module ptm_regs (
   input  wire                       sys_clk,
   input  wire                       rst,
   input  wire                       psel,
   input  wire                       penable,
   input  wire                       pwrite,
   input  wire [`PTM_PADDR_W-1:0]    paddr,
   input  wire [31:0]                pwdata,
   output reg  [31:0]                prdata,
   output reg                        pready,
   output reg                        pslverr,
   input  wire                       msg_valid,
   input  wire [3:0]                 msg_path,
   input  wire                       msg_same_prev,
   input  wire                       msg_match_exp,
   input  wire                       msg_all_zero,
   input  wire                       byte_valid,
   input  wire [3:0]                 byte_path,
   input  wire                       byte_same_prev,
   output wire [`PTM_NPATH-1:0]      identifier_unstable_defect,
   output wire [`PTM_NPATH-1:0]      identifier_mismatch_defect,
   output reg                        irq_q
);

   localparam NP = `PTM_NPATH;
   localparam CW = `PTM_CFG_W;

   // population count of the algorithm 1 match history
   function [4:0] ones20;
      input [`PTM_A1_HIST-1:0] v;
      integer k;
      begin
         ones20 = 5'h00;
         for (k = 0; k < `PTM_A1_HIST; k = k + 1) begin
            ones20 = ones20 + {4'h0, v[k]};
         end
      end
   endfunction

   reg  [15:0]       indirect_location_select_q;
   reg  [15:0]       data_q;
   reg               busy_q;
   reg  [4:0]        bcnt_q;
   reg  [NP-1:0]     uen_q;
   reg  [NP-1:0]     men_q;
   wire [NP-1:0]     unst_w;
   wire [NP-1:0]     mism_w;
   wire [NP-1:0]     uev_w;
   wire [NP-1:0]     mev_w;
   wire [NP*CW-1:0]  cfg_all;

   // apb decode
   wire [7:0]  widx    = paddr[`PTM_PADDR_W-1:2];
   wire        aligned = (paddr[1:0] == 2'h0);
   wire        acc     = psel & penable & pready;
   wire        wr      = acc & pwrite & aligned;
   wire        rd      = acc & ~pwrite & aligned;
   wire        hit_a   = aligned & (widx == `PTM_IDX_ADDR);
   wire        hit_d   = aligned & (widx == `PTM_IDX_DATA);
   wire        hit_us  = aligned & (widx == `PTM_IDX_USTATE);
   wire        hit_um  = aligned & (widx == `PTM_IDX_UMASK);
   wire        hit_ue  = aligned & (widx == `PTM_IDX_UEVENT);
   wire        hit_ms  = aligned & (widx == `PTM_IDX_MSTATE);
   wire        hit_mm  = aligned & (widx == `PTM_IDX_MMASK);
   wire        hit_me  = aligned & (widx == `PTM_IDX_MEVENT);
   wire        mapped  = hit_a | hit_d | hit_us | hit_um | hit_ue | hit_ms | hit_mm | hit_me;
   wire        clr_u   = rd & hit_ue;
   wire        clr_m   = rd & hit_me;

   // indirect access decode
   wire [7:0]  loc      = indirect_location_select_q[`PTM_IA_LOC_HI:`PTM_IA_LOC_LO];
   wire [3:0]  ipath    = indirect_location_select_q[`PTM_IA_PATH_HI:`PTM_IA_PATH_LO];
   wire        done     = busy_q & (bcnt_q == 5'h00);
   wire        path_ok  = (ipath != 4'h0) & (ipath <= NP);
   wire [3:0]  pidx     = ipath - 4'h1;
   wire [CW-1:0] cfg_sel = cfg_all[pidx*CW +: CW];

   // read data mux, unused upper bits read zero
   reg [15:0] rmux;
   always @* begin
      rmux = 16'h0000;
      if (hit_a) begin
         rmux = {busy_q, indirect_location_select_q[14:0]};
      end else if (hit_d) begin
         rmux = data_q;
      end else if (hit_us) begin
         rmux = {4'h0, unst_w};
      end else if (hit_um) begin
         rmux = {4'h0, uen_q};
      end else if (hit_ue) begin
         rmux = {4'h0, uev_w};
      end else if (hit_ms) begin
         rmux = {4'h0, mism_w};
      end else if (hit_mm) begin
         rmux = {4'h0, men_q};
      end else if (hit_me) begin
         rmux = {4'h0, mev_w};
      end
   end

   // apb slave: one wait state, answer registered
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel & penable & ~pready) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h00000000 : {16'h0000, rmux};
         pslverr <= ~mapped;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // enables, indirect address and data registers
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         uen_q   <= {NP{1'b0}};
         men_q   <= {NP{1'b0}};
         indirect_location_select_q <= 16'h0000;
         data_q  <= 16'h0000;
         busy_q  <= 1'b0;
         bcnt_q  <= 5'h00;
      end else begin
         if (wr & hit_um) begin
            uen_q <= pwdata[NP-1:0];
         end
         if (wr & hit_mm) begin
            men_q <= pwdata[NP-1:0];
         end
         if (wr & hit_a & ~busy_q) begin
            indirect_location_select_q <= {1'b0, pwdata[14:6], 2'h0, pwdata[3:0]};
            busy_q  <= 1'b1;
            bcnt_q  <= `PTM_BUSY_CYC - 5'h01;
         end else if (busy_q) begin
            bcnt_q <= bcnt_q - 5'h01;
            if (done) begin
               busy_q <= 1'b0;
            end
         end
         if (done & indirect_location_select_q[`PTM_IA_RNW]) begin
            data_q <= (path_ok & (loc == `PTM_LOC_CFG)) ? {9'h000, cfg_sel} : 16'h0000;
         end else if (wr & hit_d) begin
            data_q <= pwdata[15:0];
         end
      end
   end

   wire cfg_wr = done & ~indirect_location_select_q[`PTM_IA_RNW] & (loc == `PTM_LOC_CFG);

   genvar g;
   generate
      for (g = 0; g < NP; g = g + 1) begin : path
         localparam [3:0] PID = g + 1;

         reg  [CW-1:0]             cfg_q;
         reg  [`PTM_A1_HIST-1:0]   hist_q;
         reg  [3:0]                a2cnt_q;
         reg                       a2diff_q;
         reg  [2:0]                per_q;
         reg                       accmis_q;
         reg                       w3act_q;
         reg                       w3err_q;
         reg  [3:0]                w3byte_q;
         reg  [1:0]                w3win_q;
         reg  [5:0]                same3_q;
         reg                       unst_q;
         reg                       mism_q;
         reg                       uev_q;
         reg                       mev_q;

         reg  [`PTM_A1_HIST-1:0]   hist_d;
         reg  [3:0]                a2cnt_d;
         reg                       a2diff_d;
         reg  [2:0]                per_d;
         reg                       accmis_d;
         reg                       w3act_d;
         reg                       w3err_d;
         reg  [3:0]                w3byte_d;
         reg  [1:0]                w3win_d;
         reg  [5:0]                same3_d;
         reg                       unst_d;
         reg                       mism_d;
         reg  [4:0]                nmatch;

         wire [1:0] algo  = cfg_q[`PTM_CFG_ALGO_HI:`PTM_CFG_ALGO_LO];
         wire       hit_m = msg_valid & (msg_path == PID);
         wire       hit_b = byte_valid & (byte_path == PID);
         // all-zero message counts as match unless validation enabled
         wire       match = msg_match_exp | (msg_all_zero & ~cfg_q[`PTM_CFG_ZERO]);
         wire [2:0] need  = cfg_q[`PTM_CFG_FIVE_FRAME_PERSISTENCE] ? `PTM_A2_PER_LONG : `PTM_A2_PER_SHORT;
         wire       berr  = ~byte_same_prev;

         // detection next state for all three algorithms
         always @* begin
            hist_d   = hist_q;
            a2cnt_d  = a2cnt_q;
            a2diff_d = a2diff_q;
            per_d    = per_q;
            accmis_d = accmis_q;
            w3act_d  = w3act_q;
            w3err_d  = w3err_q;
            w3byte_d = w3byte_q;
            w3win_d  = w3win_q;
            same3_d  = same3_q;
            unst_d   = unst_q;
            mism_d   = mism_q;
            nmatch   = 5'h00;
            if (hit_m & (algo == `PTM_ALGO_1)) begin
               hist_d = {hist_q[`PTM_A1_HIST-2:0], match};
               nmatch = ones20(hist_d);
               if (nmatch == 5'h00) begin
                  mism_d = 1'b1;
               end else if (nmatch >= `PTM_A1_CLR_MIN) begin
                  mism_d = 1'b0;
               end
            end
            if (hit_m & (algo == `PTM_ALGO_2)) begin
               per_d = msg_same_prev ? ((per_q == `PTM_A2_PER_LONG) ? per_q : per_q + 3'h1) : 3'h1;
               if ((per_d == need) & (per_q != need)) begin
                  unst_d   = 1'b0;
                  a2cnt_d  = 4'h0;
                  a2diff_d = 1'b0;
                  accmis_d = ~match;
               end else begin
                  a2cnt_d  = (a2cnt_q == `PTM_A2_MSGS) ? a2cnt_q : a2cnt_q + 4'h1;
                  a2diff_d = a2diff_q | ~msg_same_prev;
                  if ((a2cnt_d == `PTM_A2_MSGS) & a2diff_d) begin
                     unst_d = 1'b1;
                  end
               end
            end
            if (algo == `PTM_ALGO_2) begin
               mism_d = accmis_d;
            end
            if (hit_b & (algo == `PTM_ALGO_3)) begin
               same3_d = byte_same_prev ? ((same3_q == `PTM_A3_SAME) ? same3_q : same3_q + 6'h01) : 6'h01;
               // window chain opens on first erroneous byte
               if (~w3act_q) begin
                  if (berr) begin
                     w3act_d  = 1'b1;
                     w3err_d  = 1'b1;
                     w3byte_d = 4'h1;
                     w3win_d  = 2'h0;
                  end
               end else begin
                  w3byte_d = w3byte_q + 4'h1;
                  w3err_d  = w3err_q | berr;
                  // any error in the third window completes the chain
                  if (berr & (w3win_q == `PTM_A3_WINS - 2'h1)) begin
                     unst_d  = 1'b1;
                     w3act_d = 1'b0;
                     w3win_d = 2'h0;
                  end else if (w3byte_q == `PTM_A3_WIN_LAST) begin
                     w3err_d = 1'b0;
                     if (w3err_q | berr) begin
                        w3win_d = w3win_q + 2'h1;
                     end else begin
                        w3act_d = 1'b0;
                        w3win_d = 2'h0;
                     end
                  end
               end
               if (same3_d == `PTM_A3_SAME) begin
                  unst_d = 1'b0;
               end
            end
            if (algo == `PTM_ALGO_1) begin
               unst_d = 1'b0;
            end
            if (algo == `PTM_ALGO_3) begin
               mism_d = 1'b0;
            end
            if (algo == `PTM_ALGO_OFF) begin
               unst_d = 1'b0;
               mism_d = 1'b0;
            end
         end

         // per-path state and event bits
         always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               cfg_q    <= `PTM_CFG_RESET;
               hist_q   <= {`PTM_A1_HIST{1'b0}};
               a2cnt_q  <= 4'h0;
               a2diff_q <= 1'b0;
               per_q    <= 3'h0;
               accmis_q <= 1'b0;
               w3act_q  <= 1'b0;
               w3err_q  <= 1'b0;
               w3byte_q <= 4'h0;
               w3win_q  <= 2'h0;
               same3_q  <= 6'h00;
               unst_q   <= 1'b0;
               mism_q   <= 1'b0;
               uev_q    <= 1'b0;
               mev_q    <= 1'b0;
            end else begin
               // configuration word store, length bit kept for the extractor
               if (cfg_wr & (ipath == PID)) begin
                  cfg_q <= data_q[CW-1:0];
               end
               hist_q   <= hist_d;
               a2cnt_q  <= a2cnt_d;
               a2diff_q <= a2diff_d;
               per_q    <= per_d;
               accmis_q <= accmis_d;
               w3act_q  <= w3act_d;
               w3err_q  <= w3err_d;
               w3byte_q <= w3byte_d;
               w3win_q  <= w3win_d;
               same3_q  <= same3_d;
               unst_q   <= unst_d;
               mism_q   <= mism_d;
               // unstable change event, read clears only the bits it returned
               uev_q <= (uev_q & ~(clr_u & prdata[g])) | (unst_d ^ unst_q);
               // mismatch change event, read clears only the bits it returned
               mev_q <= (mev_q & ~(clr_m & prdata[g])) | (mism_d ^ mism_q);
            end
         end

         assign unst_w[g]                = unst_q;
         assign mism_w[g]                = mism_q;
         assign uev_w[g]                 = uev_q;
         assign mev_w[g]                 = mev_q;
         assign cfg_all[g*CW +: CW]      = cfg_q;
      end
   endgenerate

   assign identifier_unstable_defect = unst_w;
   assign identifier_mismatch_defect = mism_w;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |((uev_w & uen_q) | (mev_w & men_q));
      end
   end

endmodule
`default_nettype wire

// ---- test/ptm_trace_src.sv ----
`timescale 1ns/1ns
`default_nettype none
// stands in for the overhead extractor that feeds messages and bytes
module ptm_trace_src (
   input  wire logic        sys_clk,
   output logic             msg_valid,
   output logic [3:0]       msg_path,
   output logic             msg_same_prev,
   output logic             msg_match_exp,
   output logic             msg_all_zero,
   output logic             byte_valid,
   output logic [3:0]       byte_path,
   output logic             byte_same_prev
);
   // quiet start, valids low, paths parked on 15 which no pulse uses
   initial begin
      msg_valid = 1'b0;
      msg_path = 4'hF;
      msg_same_prev = 1'b1;
      msg_match_exp = 1'b1;
      msg_all_zero = 1'b1;
      byte_valid = 1'b0;
      byte_path = 4'hF;
      byte_same_prev = 1'b0;
   end
   // one message pulse; qualifiers scrambled once it has gone
   task automatic send_msg(input logic [3:0] p, input logic same, input logic match);
      msg_valid <= 1'b1;
      msg_path <= p;
      msg_same_prev <= same;
      msg_match_exp <= match;
      msg_all_zero <= 1'b0;
      @(posedge sys_clk);
      msg_valid <= 1'b0;
      msg_path <= ~p;
      msg_same_prev <= ~same;
      msg_match_exp <= ~match;
      msg_all_zero <= 1'b1;
      @(posedge sys_clk);
   endtask
   // one trace byte pulse, same scrambling afterwards
   task automatic send_byte(input logic [3:0] p, input logic same);
      byte_valid <= 1'b1;
      byte_path <= p;
      byte_same_prev <= same;
      @(posedge sys_clk);
      byte_valid <= 1'b0;
      byte_path <= ~p;
      byte_same_prev <= ~same;
      @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// ---- test/ptm_regs_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ptm_consts.vh"
module ptm_regs_chk (
   input wire logic          sys_clk,
   input wire logic          rst,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [9:0]    paddr,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic          msg_valid,
   input wire logic [3:0]    msg_path,
   input wire logic          byte_valid,
   input wire logic [3:0]    byte_path,
   input wire logic [11:0]   identifier_unstable_defect,
   input wire logic [11:0]   identifier_mismatch_defect,
   input wire logic          irq_q
);
   // transfer completion, decode and the lanes a pulse may touch
   wire        done  = psel && penable && pready;
   wire [7:0]  idx   = paddr[9:2];
   wire        mapd  = paddr[1:0] == 2'h0 && idx >= `PTM_IDX_ADDR && idx <= `PTM_IDX_MEVENT;
   wire        cause = msg_valid || byte_valid || (done && pwrite);
   wire [11:0] lm    = msg_valid ? 12'h001 << (msg_path - 4'h1) : 12'h000;
   wire [11:0] lanes = lm | (byte_valid ? 12'h001 << (byte_path - 4'h1) : 12'h000);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // setup then first access cycle, and a quiet event register read
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence s_evrd(a);
      done && !pwrite && idx == a && !msg_valid && !byte_valid && !$past(msg_valid || byte_valid);
   endsequence
   property p_answer;
      s_setup |=> pready && (pslverr == !mapd);
   endproperty
   property p_ready_once;
      pready |-> psel && penable ##1 !pready;
   endproperty
   property p_irq_rise;
      $rose(irq_q) |-> $past(cause, 2);
   endproperty
   property p_irq_fall;
      $fell(irq_q) |-> $past(done, 2);
   endproperty
   property p_upper;
      done && !pwrite && idx >= `PTM_IDX_USTATE && idx <= `PTM_IDX_MEVENT |-> prdata[31:12] == 20'h00000;
   endproperty
   property p_uev_clr;
      s_evrd(`PTM_IDX_UEVENT) ##1 !(msg_valid || byte_valid) ##2 s_evrd(`PTM_IDX_UEVENT) |-> prdata[11:0] == 12'h000;
   endproperty
   property p_mev_clr;
      s_evrd(`PTM_IDX_MEVENT) ##1 !(msg_valid || byte_valid) ##2 s_evrd(`PTM_IDX_MEVENT) |-> prdata[11:0] == 12'h000;
   endproperty
   property p_unst_lane;
      1'b1 |=> (identifier_unstable_defect & ~$past(identifier_unstable_defect) & ~$past(lanes)) == 12'h000;
   endproperty
   property p_mism_lane;
      1'b1 |=> (identifier_mismatch_defect & ~$past(identifier_mismatch_defect) & ~$past(lanes)) == 12'h000;
   endproperty
   a_answer: assert property (p_answer) else $error("answer late or wrong error flag");
   a_ready_once: assert property (p_ready_once) else $error("ready outside one access cycle");
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without access");
   a_upper: assert property (p_upper) else $error("unused status bits not zero");
   a_uev_clr: assert property (p_uev_clr) else $error("unstable events kept after read");
   a_mev_clr: assert property (p_mev_clr) else $error("mismatch events kept after read");
   a_unst_lane: assert property (p_unst_lane) else $error("unstable bit set on wrong path");
   a_mism_lane: assert property (p_mism_lane) else $error("mismatch bit set on wrong path");
endmodule
bind ptm_regs ptm_regs_chk chk_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid), .msg_path(msg_path),
   .byte_valid(byte_valid), .byte_path(byte_path), .identifier_unstable_defect(identifier_unstable_defect),
   .identifier_mismatch_defect(identifier_mismatch_defect), .irq_q(irq_q));
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ptm_consts.vh"
module testbench;
   logic          sys_clk = 1'b0;
   logic          rst = 1'b1;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [9:0]    paddr = 10'h000;
   logic [31:0]   pwdata = 32'h00000000;
   wire  [31:0]   prdata;
   wire           pready, pslverr, irq_q, mv, ms, mm, mz, bv, bs;
   wire  [3:0]    mp, bp;
   wire  [11:0]   udef, mdef;
   int            mismatches = 0;
   int            checks_done = 0;
   logic [31:0]   rv;
   logic          ev;
   int            n;
   localparam [9:0] A_ADDR = {`PTM_IDX_ADDR, 2'h0}, A_DATA = {`PTM_IDX_DATA, 2'h0};
   localparam [9:0] A_UST = {`PTM_IDX_USTATE, 2'h0}, A_UMK = {`PTM_IDX_UMASK, 2'h0}, A_UEV = {`PTM_IDX_UEVENT, 2'h0};
   localparam [9:0] A_MST = {`PTM_IDX_MSTATE, 2'h0}, A_MMK = {`PTM_IDX_MMASK, 2'h0}, A_MEV = {`PTM_IDX_MEVENT, 2'h0};
   ptm_regs dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_valid(mv), .msg_path(mp),
      .msg_same_prev(ms), .msg_match_exp(mm), .msg_all_zero(mz), .byte_valid(bv), .byte_path(bp),
      .byte_same_prev(bs), .identifier_unstable_defect(udef), .identifier_mismatch_defect(mdef), .irq_q(irq_q));
   ptm_trace_src src_u (.sys_clk(sys_clk), .msg_valid(mv), .msg_path(mp), .msg_same_prev(ms), .msg_match_exp(mm),
      .msg_all_zero(mz), .byte_valid(bv), .byte_path(bp), .byte_same_prev(bs));
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   // compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one transfer, request held until ready is sampled; caller releases
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      chk("ready", {31'h0, pready}, 32'h1);
      rv = prdata;
      ev = pslverr;
   endtask
   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      idle();
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      idle();
      chk("read", rv, e);
   endtask
   // two reads back to back, for read-to-clear registers
   task automatic rdrd(input logic [9:0] a, input logic [31:0] e1, input logic [31:0] e2);
      apb(1'b0, a, 32'h0);
      chk("first read", rv, e1);
      apb(1'b0, a, 32'h0);
      idle();
      chk("second read", rv, e2);
   endtask
   // start an indirect access and poll the busy flag until it drops
   task automatic ind(input logic rnw, input logic [7:0] loc, input logic [3:0] p);
      wr(A_ADDR, {17'h0, rnw, loc, 2'h0, p});
      n = 0;
      do begin
         apb(1'b0, A_ADDR, 32'h0);
         idle();
         if (n == 0) chk("busy raised", {31'h0, rv[15]}, 32'h1);
         n++;
      end while (rv[15] !== 1'b0 && n < 10);
      chk("busy polls", {31'h0, n <= 6}, 32'h1);
   endtask
   task automatic cfg(input logic [3:0] p, input logic [15:0] v);
      wr(A_DATA, {16'h0, v});
      ind(1'b0, `PTM_LOC_CFG, p);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // watchdog cuts a hang short
   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      results();
   end
   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(A_DATA, 32'h0);
      rd(A_UMK, 32'h0);
      rd(A_MMK, 32'h0);
      apb(1'b0, 10'h3FC, 32'h0);
      chk("unmapped err", {31'h0, ev}, 32'h1);
      apb(1'b1, 10'h305, 32'h1);
      idle();
      chk("unaligned err", {31'h0, ev}, 32'h1);
      wr(A_UST, 32'hFFFF);
      rd(A_UST, 32'h0);
      wr(A_UMK, 32'hFFFF);
      rd(A_UMK, 32'h0FFF);
      wr(A_UMK, 32'h0);
      cfg(4'h1, 16'h0045);
      ind(1'b1, `PTM_LOC_CFG, 4'h1);
      rd(A_DATA, 32'h45);
      ind(1'b1, `PTM_LOC_CFG, 4'hD);
      rd(A_DATA, 32'h0);
      // first algorithm on path 1
      wr(A_MMK, 32'h1);
      src_u.send_msg(4'h1, 1'b0, 1'b0);
      rd(A_MST, 32'h1);
      chk("defect out", {20'h0, mdef}, 32'h1);
      chk("irq on", {31'h0, irq_q}, 32'h1);
      rdrd(A_MEV, 32'h1, 32'h0);
      chk("irq off", {31'h0, irq_q}, 32'h0);
      for (int i = 0; i < 15; i++) src_u.send_msg(4'h1, 1'b0, 1'b1);
      rd(A_MST, 32'h1);
      src_u.send_msg(4'h1, 1'b0, 1'b1);
      rd(A_MST, 32'h0);
      rd(A_MEV, 32'h1);
      wr(A_MMK, 32'h0);
      for (int i = 0; i < 19; i++) src_u.send_msg(4'h1, 1'b0, 1'b0);
      rd(A_MST, 32'h0);
      src_u.send_msg(4'h1, 1'b0, 1'b0);
      rd(A_MST, 32'h1);
      chk("masked irq", {31'h0, irq_q}, 32'h0);
      rd(A_MEV, 32'h1);
      rd(A_UST, 32'h0);
      // second algorithm on path 4, three then five repeats
      cfg(4'h4, 16'h0002);
      for (int i = 0; i < 7; i++) src_u.send_msg(4'h4, 1'b0, 1'b0);
      rd(A_UST, 32'h0);
      src_u.send_msg(4'h4, 1'b0, 1'b0);
      rd(A_UST, 32'h8);
      for (int i = 0; i < 4; i++) src_u.send_msg(4'h4, 1'b1, 1'b0);
      rd(A_UST, 32'h0);
      rd(A_MST, 32'h9);
      cfg(4'h4, 16'h0012);
      for (int i = 0; i < 8; i++) src_u.send_msg(4'h4, 1'b0, 1'b1);
      for (int i = 0; i < 2; i++) src_u.send_msg(4'h4, 1'b1, 1'b1);
      rd(A_UST, 32'h8);
      for (int i = 0; i < 3; i++) src_u.send_msg(4'h4, 1'b1, 1'b1);
      rd(A_UST, 32'h0);
      rd(A_MST, 32'h1);
      rdrd(A_UEV, 32'h8, 32'h0);
      rd(A_MEV, 32'h8);
      // third algorithm on path 7: errors opening three windows
      cfg(4'h7, 16'h0003);
      wr(A_UMK, 32'h40);
      for (int i = 0; i < 32; i++) src_u.send_byte(4'h7, i % 16 != 0);
      rd(A_UST, 32'h0);
      src_u.send_byte(4'h7, 1'b0);
      rd(A_UST, 32'h40);
      chk("unstable irq", {31'h0, irq_q}, 32'h1);
      rdrd(A_UEV, 32'h40, 32'h0);
      for (int i = 0; i < 46; i++) src_u.send_byte(4'h7, 1'b1);
      rd(A_UST, 32'h40);
      src_u.send_byte(4'h7, 1'b1);
      rd(A_UST, 32'h0);
      chk("defect out", {20'h0, udef}, 32'h0);
      rd(A_MST, 32'h1);
      // disabling path 1 forces its status low
      cfg(4'h1, 16'h0000);
      rd(A_MST, 32'h0);
      src_u.send_msg(4'h1, 1'b0, 1'b0);
      rd(A_MST, 32'h0);
      chk("defect off", {20'h0, mdef}, 32'h0);
      results();
   end
endmodule
`default_nettype wire
